/* design/pin_a_channel.v */
// One channel's pin-A compare/capture unit steered by its four-bit mode field
`timescale 1ns/1ps
`default_nettype none
`include "pin_a_io_map.vh"

module pin_a_channel #(
  parameter CNT_W = 16,
  parameter HAS_CASCADE = 0
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire [3:0] mode_i,
  input wire mode_wr_i,
  input wire [CNT_W-1:0] count_i,
  input wire reg_wr_i,
  input wire [CNT_W-1:0] reg_wdata_i,
  input wire cascade_evt_i,
  input wire pin_i,
  output wire pin_o,
  output wire pin_oe_o,
  output wire [CNT_W-1:0] reg_a_o,
  output wire capture_o,
  output wire match_o
);

  reg [CNT_W-1:0] reg_a_r;
  reg level_r;
  reg pin_prev_r;
  reg equal_prev_r;
  wire is_capture;
  wire cascade_sel;
  wire equal_now;
  wire pin_edge_hit;
  reg level_nxt;

  // =====================================================================
  // Edge qualifier for the selected capture edge
  function edge_hit;
    input [1:0] low_bits;
    input prev;
    input cur;
    begin
      if (low_bits[1]) begin
        edge_hit = prev ^ cur;
      end else if (low_bits[0]) begin
        edge_hit = prev & ~cur;
      end else begin
        edge_hit = ~prev & cur;
      end
    end
  endfunction

  // =====================================================================
  // Mode decode
  assign is_capture = mode_i[`MODE_BIT_CAPTURE];
  // In capture use, bit 2 only matters on the cascading channel
  assign cascade_sel = (HAS_CASCADE != 0) && is_capture &&
                       mode_i[`MODE_BIT_INIT_HIGH];
  assign pin_edge_hit = edge_hit(mode_i[1:0], pin_prev_r, pin_i);
  // Capture fires in the cycle the event is seen
  assign capture_o = is_capture &&
                     (cascade_sel ? cascade_evt_i : pin_edge_hit);

  // Match only on the first cycle of equality, so a stopped counter
  // does not toggle the pin every clock
  assign equal_now = (count_i == reg_a_r);
  assign match_o = !is_capture && equal_now && !equal_prev_r;

  assign pin_oe_o = !is_capture && (mode_i[1:0] != 2'b00);
  assign pin_o = pin_oe_o ? level_r : 1'b0;
  assign reg_a_o = reg_a_r;

  // =====================================================================
  // Pin level
  always @* begin
    level_nxt = level_r;
    if (mode_wr_i) begin
      level_nxt = mode_i[`MODE_BIT_INIT_HIGH];
    end else if (match_o) begin
      case (mode_i[1:0])
        2'b01: level_nxt = 1'b0;
        2'b10: level_nxt = 1'b1;
        2'b11: level_nxt = ~level_r;
        default: level_nxt = level_r;
      endcase
    end
  end

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      level_r <= 1'b0;
      pin_prev_r <= 1'b0;
      // Counter and register both reset to zero, so equality is the idle
      // state; starting high keeps reset from posing as a match
      equal_prev_r <= 1'b1;
      reg_a_r <= {CNT_W{1'b0}};
    end else begin
      level_r <= level_nxt;
      pin_prev_r <= pin_i;
      equal_prev_r <= equal_now;
      // Capture beats a software write in the same cycle
      if (capture_o) begin
        reg_a_r <= count_i;
      end else if (reg_wr_i) begin
        reg_a_r <= reg_wdata_i;
      end
    end
  end

endmodule
`default_nettype wire

/* design/pin_a_io_map.vh */
// Register map, mode field layout and reset values for the pin-A mode block
`ifndef PIN_A_IO_MAP_VH
`define PIN_A_IO_MAP_VH

// =====================================================================
// Register byte offsets
`define OFF_CH4_IO_CONTROL 8'h00
`define OFF_CH5_IO_CONTROL 8'h04
`define OFF_CH4_GENERAL_REG_A 8'h08
`define OFF_CH5_GENERAL_REG_A 8'h0c
`define OFF_EVENT_STATUS 8'h10
`define OFF_PIN_STATUS 8'h14

// =====================================================================
// Mode field positions inside an io_control register
`define MODE_A_LSB 0
`define MODE_A_MSB 3
`define MODE_BIT_CAPTURE 3
`define MODE_BIT_INIT_HIGH 2
`define MODE_BIT_BOTH_EDGES 1
`define MODE_BIT_FALLING 0

// =====================================================================
// Event status bit positions (write one to clear)
`define EVT_CH4_CAPTURE 0
`define EVT_CH4_MATCH 1
`define EVT_CH5_CAPTURE 2
`define EVT_CH5_MATCH 3

// =====================================================================
// Reset values
`define RST_IO_CONTROL 8'h00
`define RST_GENERAL_REG_A 16'h0000
`define RST_EVENT_STATUS 4'h0

// =====================================================================
// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* design/pin_a_io_mode.v */
// Channel 4/5 pin-A mode select with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "pin_a_io_map.vh"

module pin_a_io_mode #(
  parameter CNT_W = 16
) (
  input wire core_clk_i,
  input wire reset_i,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Timer side
  input wire [CNT_W-1:0] ch4_count_i,
  input wire [CNT_W-1:0] ch5_count_i,
  input wire ch3_a_event_i,
  input wire ch4_pin_a_i,
  output wire ch4_pin_a_o,
  output wire ch4_pin_a_oe_o,
  input wire ch5_pin_a_i,
  output wire ch5_pin_a_o,
  output wire ch5_pin_a_oe_o
);

  // =====================================================================
  // Registers
  reg [7:0] ch4_io_control_r;
  reg [7:0] ch5_io_control_r;
  reg [3:0] event_status_r;
  reg [3:0] event_status_nxt;

  // Write channel state
  reg aw_held_r;
  reg [7:0] aw_addr_r;
  reg w_held_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg bvalid_r;
  reg [1:0] bresp_r;

  // Read channel state
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;

  wire do_write;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire do_read;

  wire ch4_mode_wr;
  wire ch5_mode_wr;
  wire ch4_reg_wr;
  wire ch5_reg_wr;
  wire [CNT_W-1:0] ch4_reg_wdata;
  wire [CNT_W-1:0] ch5_reg_wdata;
  wire [CNT_W-1:0] ch4_reg_a;
  wire [CNT_W-1:0] ch5_reg_a;
  wire ch4_capture;
  wire ch4_match;
  wire ch5_capture;
  wire ch5_match;
  wire wr_hit;
  wire [31:0] ch4_merged;
  wire [31:0] ch5_merged;
  reg ch4_mode_wr_r;
  reg ch5_mode_wr_r;

  // =====================================================================
  // Helpers
  function is_mapped;
    input [7:0] addr;
    begin
      case (addr)
        `OFF_CH4_IO_CONTROL,
        `OFF_CH5_IO_CONTROL,
        `OFF_CH4_GENERAL_REG_A,
        `OFF_CH5_GENERAL_REG_A,
        `OFF_EVENT_STATUS,
        `OFF_PIN_STATUS: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Byte-lane merge of a write into an existing 32-bit word
  function [31:0] merge_lanes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      merge_lanes = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge_lanes[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // =====================================================================
  // Write address and data, taken in either order
  // A channel is ready only while its own item is not yet held and no
  // response is pending, so one write at a time is under way.
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;

  assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  assign do_write = !bvalid_r &&
                    (aw_held_r || s_axi_awvalid) &&
                    (w_held_r || s_axi_wvalid);
  assign wr_hit = is_mapped({wr_addr[7:2], 2'b00});

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
          bvalid_r <= 1'b0;
        end
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // =====================================================================
  // Register write decode
  assign ch4_mode_wr = do_write && ({wr_addr[7:2], 2'b00} == `OFF_CH4_IO_CONTROL) &&
                       wr_strb[0];
  assign ch5_mode_wr = do_write && ({wr_addr[7:2], 2'b00} == `OFF_CH5_IO_CONTROL) &&
                       wr_strb[0];
  assign ch4_reg_wr = do_write && ({wr_addr[7:2], 2'b00} == `OFF_CH4_GENERAL_REG_A) &&
                      (wr_strb[1:0] != 2'b00);
  assign ch5_reg_wr = do_write && ({wr_addr[7:2], 2'b00} == `OFF_CH5_GENERAL_REG_A) &&
                      (wr_strb[1:0] != 2'b00);

  // Only the low counter-width bits exist; upper lanes are dropped on purpose
  assign ch4_merged = merge_lanes({{(32-CNT_W){1'b0}}, ch4_reg_a}, wr_data, wr_strb);
  assign ch5_merged = merge_lanes({{(32-CNT_W){1'b0}}, ch5_reg_a}, wr_data, wr_strb);
  assign ch4_reg_wdata = ch4_merged[CNT_W-1:0];
  assign ch5_reg_wdata = ch5_merged[CNT_W-1:0];

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ch4_io_control_r <= `RST_IO_CONTROL;
      ch5_io_control_r <= `RST_IO_CONTROL;
    end else begin
      if (ch4_mode_wr) begin
        ch4_io_control_r <= wr_data[7:0];
      end
      if (ch5_mode_wr) begin
        ch5_io_control_r <= wr_data[7:0];
      end
    end
  end

  // =====================================================================
  // Initial level load, one cycle after the mode write
  // The channel reads its mode from the register, which only holds the
  // new code after the write edge; loading at the write itself would
  // start the pin from the old code's level.
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ch4_mode_wr_r <= 1'b0;
      ch5_mode_wr_r <= 1'b0;
    end else begin
      ch4_mode_wr_r <= ch4_mode_wr;
      ch5_mode_wr_r <= ch5_mode_wr;
    end
  end

  // =====================================================================
  // Sticky event flags; a new event wins over a clear in the same cycle
  always @* begin
    event_status_nxt = event_status_r;
    if (do_write && ({wr_addr[7:2], 2'b00} == `OFF_EVENT_STATUS) && wr_strb[0]) begin
      event_status_nxt = event_status_r & ~wr_data[3:0];
    end
    if (ch4_capture) begin
      event_status_nxt[`EVT_CH4_CAPTURE] = 1'b1;
    end
    if (ch4_match) begin
      event_status_nxt[`EVT_CH4_MATCH] = 1'b1;
    end
    if (ch5_capture) begin
      event_status_nxt[`EVT_CH5_CAPTURE] = 1'b1;
    end
    if (ch5_match) begin
      event_status_nxt[`EVT_CH5_MATCH] = 1'b1;
    end
  end

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      event_status_r <= `RST_EVENT_STATUS;
    end else begin
      event_status_r <= event_status_nxt;
    end
  end

  // =====================================================================
  // Read channel: data one cycle after the address is taken
  assign s_axi_arready = !rvalid_r;
  assign do_read = s_axi_arvalid && !rvalid_r;

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else begin
      if (do_read) begin
        rvalid_r <= 1'b1;
        rresp_r <= `RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
          `OFF_CH4_IO_CONTROL: rdata_r <= {24'h000000, ch4_io_control_r};
          `OFF_CH5_IO_CONTROL: rdata_r <= {24'h000000, ch5_io_control_r};
          `OFF_CH4_GENERAL_REG_A: rdata_r <= {{(32-CNT_W){1'b0}}, ch4_reg_a};
          `OFF_CH5_GENERAL_REG_A: rdata_r <= {{(32-CNT_W){1'b0}}, ch5_reg_a};
          `OFF_EVENT_STATUS: rdata_r <= {28'h0000000, event_status_r};
          `OFF_PIN_STATUS: rdata_r <= {28'h0000000, ch5_pin_a_oe_o, ch5_pin_a_o,
                                       ch4_pin_a_oe_o, ch4_pin_a_o};
          default: begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= `RESP_SLVERR;
          end
        endcase
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // =====================================================================
  // Channel units
  pin_a_channel #(
    .CNT_W(CNT_W),
    .HAS_CASCADE(1)
  ) u_ch4 (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .mode_i(ch4_io_control_r[`MODE_A_MSB:`MODE_A_LSB]),
    .mode_wr_i(ch4_mode_wr_r),
    .count_i(ch4_count_i),
    .reg_wr_i(ch4_reg_wr),
    .reg_wdata_i(ch4_reg_wdata),
    .cascade_evt_i(ch3_a_event_i),
    .pin_i(ch4_pin_a_i),
    .pin_o(ch4_pin_a_o),
    .pin_oe_o(ch4_pin_a_oe_o),
    .reg_a_o(ch4_reg_a),
    .capture_o(ch4_capture),
    .match_o(ch4_match)
  );

  // Channel 5 has no cascade source, so bit 2 drops out in capture use
  pin_a_channel #(
    .CNT_W(CNT_W),
    .HAS_CASCADE(0)
  ) u_ch5 (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .mode_i(ch5_io_control_r[`MODE_A_MSB:`MODE_A_LSB]),
    .mode_wr_i(ch5_mode_wr_r),
    .count_i(ch5_count_i),
    .reg_wr_i(ch5_reg_wr),
    .reg_wdata_i(ch5_reg_wdata),
    .cascade_evt_i(1'b0),
    .pin_i(ch5_pin_a_i),
    .pin_o(ch5_pin_a_o),
    .pin_oe_o(ch5_pin_a_oe_o),
    .reg_a_o(ch5_reg_a),
    .capture_o(ch5_capture),
    .match_o(ch5_match)
  );

endmodule
`default_nettype wire

/* verif/pin_a_io_mode_asserts.sv */
// Port assertions for the channel 4/5 pin-A mode block
`timescale 1ns/1ps
`default_nettype none
module pin_a_io_mode_asserts #(parameter CNT_W = 16) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CNT_W-1:0] ch4_count_i,
  input wire logic ch4_pin_a_o,
  input wire logic ch4_pin_a_oe_o,
  input wire logic ch5_pin_a_o,
  input wire logic ch5_pin_a_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // ===================================================================
  // Pin side
  chk_off_pin4_low: assert property (!ch4_pin_a_oe_o |-> !ch4_pin_a_o)
    else $error("ch4 pin high while disabled");
  chk_off_pin5_low: assert property (!ch5_pin_a_oe_o |-> !ch5_pin_a_o)
    else $error("ch5 pin high while disabled");
  // A level change needs a write or a fresh arrival of the counter
  chk_pin_change_cause: assert property ($stable(ch4_pin_a_oe_o) && ch4_pin_a_oe_o &&
    $changed(ch4_pin_a_o) |-> s_axi_bvalid || $past(s_axi_bvalid) ||
    $past(ch4_count_i) != $past(ch4_count_i, 2)) else $error("ch4 pin moved without cause");
  // ===================================================================
  // Register bus
  chk_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> s_axi_bvalid) else $error("write response late");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after handshake");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after handshake");
  cov_toggle: cover property (ch4_pin_a_oe_o && $changed(ch4_pin_a_o));
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind pin_a_io_mode pin_a_io_mode_asserts #(.CNT_W(CNT_W)) u_chk (.core_clk_i, .reset_i,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .ch4_count_i, .ch4_pin_a_o, .ch4_pin_a_oe_o, .ch5_pin_a_o, .ch5_pin_a_oe_o);
`default_nettype wire

/* verif/pin_a_io_mode_tb.sv */
// Self-checking bench for the channel 4/5 pin-A mode block
`timescale 1ns/1ps
`default_nettype none
`include "pin_a_io_map.vh"
module pin_a_io_mode_tb;
  logic core_clk_i = 0;
  logic reset_i = 1;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
  logic awr, wr_rdy, bv, arr, rv, p4o, p4e, p5o, p5e, m4, m5, ev3;
  logic [1:0] bresp, rresp;
  logic [15:0] cnt = 16'h0000;
  int n_errors = 0, compares = 0, cycles = 0;
  // ===================================================================
  // Pin wires: the driving party wins
  wire p4 = p4e ? p4o : m4;
  wire p5 = p5e ? p5o : m5;
  pin_a_io_mode #(.CNT_W(16)) DUT (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ar_a), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .ch4_count_i(cnt), .ch5_count_i(cnt), .ch3_a_event_i(ev3),
    .ch4_pin_a_i(p4), .ch4_pin_a_o(p4o), .ch4_pin_a_oe_o(p4e), .ch5_pin_a_i(p5),
    .ch5_pin_a_o(p5o), .ch5_pin_a_oe_o(p5e));
  pin_side_model PM (.core_clk_i(core_clk_i), .ch4_pin_o(m4), .ch5_pin_o(m5),
    .ch3_event_o(ev3));
  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  // ===================================================================
  // Shared tasks
  task automatic finish_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Readies are sampled at the falling edge, where they have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge core_clk_i);
    aw_a <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge core_clk_i);
      ta = awv && awr;
      tw = wv && wr_rdy;
      tb = bv;
      r = bresp;
      @(posedge core_clk_i);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    brdy <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge core_clk_i);
    ar_a <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge core_clk_i);
      ta = arv && arr;
      tr = rv;
      d = rdat;
      r = rresp;
      @(posedge core_clk_i);
      if (ta) arv <= 1'b0;
    end
    rrdy <= 1'b0;
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  // ===================================================================
  // Scenarios
  task automatic check_reset();
    for (int a = 0; a < 24; a += 4) rd_chk(a[7:0], 32'h0, `RESP_OKAY);
    rd_chk(8'h1c, 32'h0, `RESP_SLVERR);
    wr(8'h20, 32'h5, `RESP_SLVERR);
    chk("ch4 oe", 32'h0, {31'h0, p4e});
  endtask
  task automatic check_compare();
    logic [3:0] m;
    logic e;
    for (int ch = 4; ch <= 5; ch++) begin
      for (int c = 0; c < 8; c++) begin
        m = c[3:0];
        wr(ch == 4 ? `OFF_CH4_GENERAL_REG_A : `OFF_CH5_GENERAL_REG_A, 32'h10, `RESP_OKAY);
        wr(ch == 4 ? `OFF_CH4_IO_CONTROL : `OFF_CH5_IO_CONTROL, {28'h0, m}, `RESP_OKAY);
        @(negedge core_clk_i);
        chk("oe", {31'h0, m[1:0] != 2'b00}, {31'h0, ch == 4 ? p4e : p5e});
        e = m[2] && m[1:0] != 2'b00;
        chk("initial level", {31'h0, e}, {31'h0, ch == 4 ? p4o : p5o});
        for (int t = 0; t < 2; t++) begin
          @(posedge core_clk_i);
          cnt <= 16'h0010;
          repeat (3) @(posedge core_clk_i);
          cnt <= 16'h0000;
          @(negedge core_clk_i);
          e = m[1:0] == 2'b10 || (m[1:0] == 2'b11 && (m[2] ^ (t == 0)));
          chk("match level", {31'h0, e}, {31'h0, ch == 4 ? p4o : p5o});
        end
      end
    end
    // Both channels end in toggle mode at level 1 with the output on
    rd_chk(`OFF_PIN_STATUS, 32'hf, `RESP_OKAY);
    // Both channels matched; write one clears and nothing re-arms the flags
    rd_chk(`OFF_EVENT_STATUS, 32'ha, `RESP_OKAY);
    wr(`OFF_EVENT_STATUS, 32'hf, `RESP_OKAY);
    rd_chk(`OFF_EVENT_STATUS, 32'h0, `RESP_OKAY);
  endtask
  task automatic check_capture();
    logic [3:0] m;
    logic [31:0] e;
    logic [15:0] v;
    logic own, cap;
    for (int ch = 4; ch <= 5; ch++) begin
      for (int c = 8; c < 16; c++) begin
        m = c[3:0];
        wr(ch == 4 ? `OFF_CH4_IO_CONTROL : `OFF_CH5_IO_CONTROL, {28'h0, m}, `RESP_OKAY);
        wr(ch == 4 ? `OFF_CH4_GENERAL_REG_A : `OFF_CH5_GENERAL_REG_A, 32'h0, `RESP_OKAY);
        e = 32'h0;
        own = !(ch == 4 && m[2]);
        for (int k = 2; k >= 0; k--) begin
          v = 16'h1000 + 16'(c * 16 + k);
          @(posedge core_clk_i);
          cnt <= v;
          if (k == 2) PM.fire_ch3();
          else PM.set_pin(ch, k[0]);
          // Counter moves on at once, so a late copy is caught
          @(posedge core_clk_i);
          cnt <= v + 16'h1;
          cap = k == 2 ? !own : own && (m[1] || m[0] == !k[0]);
          if (cap) e = {16'h0, v};
          rd_chk(ch == 4 ? `OFF_CH4_GENERAL_REG_A : `OFF_CH5_GENERAL_REG_A, e, `RESP_OKAY);
        end
      end
    end
    // Captures on both channels, no compare match since the last clear
    rd_chk(`OFF_EVENT_STATUS, 32'h5, `RESP_OKAY);
  endtask
  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    check_reset();
    check_compare();
    check_capture();
    finish_test();
  end
endmodule
`default_nettype wire

/* verif/pin_side_model.sv */
// Model of the external pin drivers and the channel 3 register-A event source
`timescale 1ns/1ps
`default_nettype none
module pin_side_model (
  input wire logic core_clk_i,
  output logic ch4_pin_o,
  output logic ch5_pin_o,
  output logic ch3_event_o
);
  initial begin
    ch4_pin_o = 1'b0;
    ch5_pin_o = 1'b0;
    ch3_event_o = 1'b0;
  end
  // One clock wide, as one channel 3 match or capture would be
  always @(posedge core_clk_i) begin
    if (ch3_event_o) ch3_event_o <= 1'b0;
  end
  task automatic set_pin(input int ch, input logic lvl);
    if (ch == 4) ch4_pin_o <= lvl;
    else ch5_pin_o <= lvl;
  endtask
  task automatic fire_ch3();
    ch3_event_o <= 1'b1;
  endtask
endmodule
`default_nettype wire
